// *** hw/sfhp_regs.svh ***
// sfhp_regs.svh: offsets, field positions, opcodes and sizes of the status and protect block.
// assumes: included by the package, the principal design file and the property checker only.
`ifndef SFHP_REGS_SVH
`define SFHP_REGS_SVH

// ==========================================================
// status register fields
`define SFHP_BIT_BUSY      0
`define SFHP_BIT_WEL       1
`define SFHP_BIT_LVL_LO    2
`define SFHP_BIT_LVL_HI    4
`define SFHP_BIT_BOTTOM    5
`define SFHP_BIT_RSVD      6
`define SFHP_BIT_LOCK      7
`define SFHP_STATUS_W      8
`define SFHP_RSVD_VALUE    1'h0

// ==========================================================
// opcodes
`define SFHP_OP_WRITE_ENABLE  8'h06
`define SFHP_OP_WRITE_DISABLE 8'h04
`define SFHP_OP_READ_STATUS   8'h05
`define SFHP_OP_WRITE_STATUS  8'h01
`define SFHP_OP_PAGE_PROGRAM  8'h02
`define SFHP_OP_SECTOR_ERASE  8'h20
`define SFHP_OP_SECTOR_ERASE2 8'hD7
`define SFHP_OP_BLOCK_ERASE   8'hD8
`define SFHP_OP_CHIP_ERASE    8'h60
`define SFHP_OP_CHIP_ERASE2   8'hC7

// ==========================================================
// frame sizes in bytes, opcode included
`define SFHP_LEN_BARE      3'h1
`define SFHP_LEN_STATUS_WR 3'h2
`define SFHP_LEN_ADDRESSED 3'h4
`define SFHP_LEN_PROGRAM   3'h5
`define SFHP_ADDR_W        24
`define SFHP_BLOCK_HI      19
`define SFHP_BLOCK_LO      16
`define SFHP_BLOCKS        5'h10

`endif

// *** hw/sfhp_pkg.sv ***
// sfhp_pkg.sv: types shared by the status and protect block.
// assumes: sfhp_regs.svh sits on the include path.
`default_nettype none
`include "sfhp_regs.svh"

package sfhp_pkg;

   // ==========================================================
   // serial frame phases
   typedef enum logic [2:0] {
      SFHP_IDLE,
      SFHP_OPCODE,
      SFHP_PAYLOAD,
      SFHP_READ_STATUS,
      SFHP_DISCARD
   } sfhp_phase_t;

   // ==========================================================
   // kinds of array operation handed to the engine
   typedef enum logic [1:0] {
      SFHP_KIND_PROGRAM,
      SFHP_KIND_SECTOR,
      SFHP_KIND_BLOCK,
      SFHP_KIND_CHIP
   } sfhp_kind_t;

endpackage : sfhp_pkg

`default_nettype wire

// *** hw/sfhp_core.sv ***
// sfhp_core.sv: status register, write protection and pause logic of a serial flash port.
// assumes: pins arrive asynchronous to clk_i and are sampled several times per serial clock;
// the array engine runs on clk_i and reports running and completion.
`default_nettype none
`include "sfhp_regs.svh"

module sfhp_core (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    clk_en_i,
   input  wire logic                    select_n_i,
   input  wire logic                    sck_i,
   input  wire logic                    si_i,
   input  wire logic                    hold_n_i,
   input  wire logic                    guard_n_i,
   input  wire logic [5:0]              nv_restore_i,
   input  wire logic                    op_running_i,
   input  wire logic                    op_done_i,
   output logic                         so_o,
   output logic                         so_oe_o,
   output logic                         paused_o,
   output logic                         busy_o,
   output logic                         write_enable_latch_o,
   output logic [2:0]                   protect_level_o,
   output logic                         protect_bottom_select_o,
   output logic                         protect_lockdown_o,
   output logic                         nv_store_o,
   output logic [5:0]                   nv_store_data_o,
   output logic                         op_start_o,
   output sfhp_pkg::sfhp_kind_t         op_kind_o,
   output logic [`SFHP_ADDR_W-1:0]      op_addr_o
);

   // ==========================================================
   // pin synchronisers
   logic [4:0] pin_meta;
   logic [4:0] pin_sync;
   logic [4:0] pin_last;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // idle pin levels: select, pause and guard high, serial clock low
         pin_meta <= 5'h1D;
         pin_sync <= 5'h1D;
         pin_last <= 5'h1D;
      end else if (clk_en_i) begin
         pin_meta <= {guard_n_i, hold_n_i, si_i, sck_i, select_n_i};
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   logic sel_n;
   logic sck;
   logic si;
   logic hold_n;
   logic guard_n;
   logic sck_rise;
   logic sck_fall;
   logic sel_rise;
   logic hold_fall;
   logic hold_rise;

   assign sel_n     = pin_sync[0];
   assign sck       = pin_sync[1];
   assign si        = pin_sync[2];
   assign hold_n    = pin_sync[3];
   assign guard_n   = pin_sync[4];
   assign sck_rise  = sck & ~pin_last[1];
   assign sck_fall  = ~sck & pin_last[1];
   assign sel_rise  = sel_n & ~pin_last[0];
   assign hold_fall = ~hold_n & pin_last[3];
   assign hold_rise = hold_n & ~pin_last[3];

   // ==========================================================
   // pause
   // the sampled serial clock of the previous cycle qualifies the pause edge, since the
   // host only moves the pause pin while the clock stays low
   logic paused;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         paused <= 1'b0;
      end else if (clk_en_i) begin
         if (sel_n) begin
            paused <= 1'b0;
         end else if (hold_fall && !pin_last[1]) begin
            paused <= 1'b1;
         end else if (hold_rise && !pin_last[1]) begin
            paused <= 1'b0;
         end
      end
   end

   assign paused_o = paused;

   // serial edges seen only while selected and not paused
   logic live_rise;
   logic live_fall;

   assign live_rise = sck_rise & ~sel_n & ~paused;
   assign live_fall = sck_fall & ~sel_n & ~paused;

   // ==========================================================
   // status bits
   logic       write_enable_latch;
   logic [2:0] level;
   logic       bottom;
   logic       lockdown;
   logic       restored;
   logic [7:0] status;

   assign status = {lockdown, `SFHP_RSVD_VALUE, bottom, level, write_enable_latch, op_running_i};

   // ==========================================================
   // protected area decode
   function automatic logic sfhp_hits(input logic [2:0]  lvl,
                                      input logic        bot,
                                      input logic [3:0]  blk);
      logic [4:0] count;
      count = 5'h00;
      sfhp_hits = 1'b0;
      if (lvl >= 3'h5) begin
         sfhp_hits = 1'b1;
      end else if (lvl != 3'h0) begin
         count = 5'h01 << (lvl - 3'h1);
         if (bot) begin
            sfhp_hits = {1'b0, blk} < count;
         end else begin
            sfhp_hits = {1'b0, blk} >= (`SFHP_BLOCKS - count);
         end
      end
   endfunction : sfhp_hits

   // ==========================================================
   // frame shifter
   sfhp_pkg::sfhp_phase_t phase;
   logic [2:0]  bit_cnt;
   logic [2:0]  byte_cnt;
   logic [7:0]  shift_in;
   logic [7:0]  opcode;
   logic [7:0]  data_byte;
   logic [`SFHP_ADDR_W-1:0] addr;
   logic [7:0]  shift_out;
   logic [7:0]  next_byte;
   logic        byte_end;

   assign next_byte = {shift_in[6:0], si};
   assign byte_end  = live_rise && (bit_cnt == 3'h7);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase    <= sfhp_pkg::SFHP_IDLE;
         bit_cnt  <= 3'h0;
         byte_cnt <= 3'h0;
         shift_in <= 8'h00;
         opcode   <= 8'h00;
         data_byte <= 8'h00;
         addr     <= 24'h000000;
      end else if (clk_en_i) begin
         if (sel_n) begin
            phase   <= sfhp_pkg::SFHP_IDLE;
            bit_cnt <= 3'h0;
         end else if (live_rise) begin
            bit_cnt  <= bit_cnt + 3'h1;
            shift_in <= next_byte;
            if (phase == sfhp_pkg::SFHP_IDLE) begin
               phase    <= sfhp_pkg::SFHP_OPCODE;
               byte_cnt <= 3'h0;
            end
            if (byte_end) begin
               if (byte_cnt != 3'h7) begin
                  byte_cnt <= byte_cnt + 3'h1;
               end
               case (phase)
                  sfhp_pkg::SFHP_IDLE,
                  sfhp_pkg::SFHP_OPCODE: begin
                     opcode <= next_byte;
                     if (next_byte == `SFHP_OP_READ_STATUS) begin
                        phase <= sfhp_pkg::SFHP_READ_STATUS;
                     end else if (op_running_i) begin
                        phase <= sfhp_pkg::SFHP_DISCARD;
                     end else begin
                        phase <= sfhp_pkg::SFHP_PAYLOAD;
                     end
                  end
                  sfhp_pkg::SFHP_PAYLOAD: begin
                     if (byte_cnt < 3'h4) begin
                        addr <= {addr[15:0], next_byte};
                     end
                     if (byte_cnt == 3'h1) begin
                        data_byte <= next_byte;
                     end
                  end
                  sfhp_pkg::SFHP_READ_STATUS,
                  sfhp_pkg::SFHP_DISCARD: begin
                  end
                  default: begin
                     phase <= sfhp_pkg::SFHP_DISCARD;
                  end
               endcase
            end
         end
      end
   end

   // ==========================================================
   // status read-out, shifted on the falling serial clock
   // busy is re-sampled each byte so a polling host sees completion
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_out <= 8'h00;
         so_o      <= 1'b0;
      end else if (clk_en_i) begin
         if (byte_end) begin
            shift_out <= status;
         end else if (live_fall && phase == sfhp_pkg::SFHP_READ_STATUS) begin
            so_o      <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
         end
      end
   end

   assign so_oe_o = ~sel_n & ~paused & (phase == sfhp_pkg::SFHP_READ_STATUS);

   // ==========================================================
   // command execution at deselect on a byte boundary
   logic frame_ok;
   logic is_write_enable_cmd;
   logic is_write_disable_cmd;
   logic is_status_write_cmd;
   logic is_prog;
   logic is_sector;
   logic is_block;
   logic is_chip;
   logic guard_lock;
   logic area_hit;
   logic write_ok;

   assign frame_ok  = sel_rise && !paused && bit_cnt == 3'h0 &&
                      phase == sfhp_pkg::SFHP_PAYLOAD && !op_running_i;
   assign is_write_enable_cmd   = frame_ok && opcode == `SFHP_OP_WRITE_ENABLE &&
                      byte_cnt == `SFHP_LEN_BARE;
   assign is_write_disable_cmd   = frame_ok && opcode == `SFHP_OP_WRITE_DISABLE &&
                      byte_cnt == `SFHP_LEN_BARE;
   assign is_status_write_cmd   = frame_ok && opcode == `SFHP_OP_WRITE_STATUS &&
                      byte_cnt == `SFHP_LEN_STATUS_WR;
   assign is_prog   = frame_ok && opcode == `SFHP_OP_PAGE_PROGRAM &&
                      byte_cnt >= `SFHP_LEN_PROGRAM;
   assign is_sector = frame_ok && byte_cnt == `SFHP_LEN_ADDRESSED &&
                      (opcode == `SFHP_OP_SECTOR_ERASE || opcode == `SFHP_OP_SECTOR_ERASE2);
   assign is_block  = frame_ok && opcode == `SFHP_OP_BLOCK_ERASE &&
                      byte_cnt == `SFHP_LEN_ADDRESSED;
   assign is_chip   = frame_ok && byte_cnt == `SFHP_LEN_BARE &&
                      (opcode == `SFHP_OP_CHIP_ERASE || opcode == `SFHP_OP_CHIP_ERASE2);

   // the write path depends on the host sending write-enable first
   assign guard_lock = ~guard_n & lockdown;
   assign area_hit   = sfhp_hits(level, bottom, addr[`SFHP_BLOCK_HI:`SFHP_BLOCK_LO]);
   assign write_ok   = write_enable_latch & ~area_hit;

   // ==========================================================
   // write-enable latch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         write_enable_latch <= 1'b0;
      end else if (clk_en_i) begin
         if (op_done_i || is_write_disable_cmd || (is_status_write_cmd && !guard_lock)) begin
            write_enable_latch <= 1'b0;
         end
         if (is_write_enable_cmd) begin
            write_enable_latch <= 1'b1;
         end
      end
   end

   // ==========================================================
   // non-volatile protection bits
   // the stored copy is taken one cycle after reset release, never during reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level      <= 3'h0;
         bottom     <= 1'b0;
         lockdown   <= 1'b0;
         restored   <= 1'b0;
         nv_store_o <= 1'b0;
      end else if (clk_en_i) begin
         nv_store_o <= 1'b0;
         if (!restored) begin
            restored <= 1'b1;
            {lockdown, bottom, level} <= {nv_restore_i[5], nv_restore_i[3:0]};
         end else if (is_status_write_cmd && write_enable_latch && !guard_lock) begin
            level      <= data_byte[`SFHP_BIT_LVL_HI:`SFHP_BIT_LVL_LO];
            bottom     <= data_byte[`SFHP_BIT_BOTTOM];
            lockdown   <= data_byte[`SFHP_BIT_LOCK];
            nv_store_o <= 1'b1;
         end
      end
   end

   assign nv_store_data_o = {lockdown, `SFHP_RSVD_VALUE, bottom, level};

   // ==========================================================
   // array operation launch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op_start_o <= 1'b0;
         op_kind_o  <= sfhp_pkg::SFHP_KIND_PROGRAM;
         op_addr_o  <= 24'h000000;
      end else if (clk_en_i) begin
         op_start_o <= 1'b0;
         op_addr_o  <= addr;
         if (is_prog && write_ok) begin
            op_start_o <= 1'b1;
            op_kind_o  <= sfhp_pkg::SFHP_KIND_PROGRAM;
         end else if (is_sector && write_ok) begin
            op_start_o <= 1'b1;
            op_kind_o  <= sfhp_pkg::SFHP_KIND_SECTOR;
         end else if (is_block && write_ok) begin
            op_start_o <= 1'b1;
            op_kind_o  <= sfhp_pkg::SFHP_KIND_BLOCK;
         end else if (is_chip && write_enable_latch && level == 3'h0 && !bottom) begin
            op_start_o <= 1'b1;
            op_kind_o  <= sfhp_pkg::SFHP_KIND_CHIP;
         end
      end
   end

   assign busy_o                  = op_running_i;
   assign write_enable_latch_o    = write_enable_latch;
   assign protect_level_o         = level;
   assign protect_bottom_select_o = bottom;
   assign protect_lockdown_o      = lockdown;

endmodule : sfhp_core

`default_nettype wire

// *** verification/sfhp_host.sv ***
// sfhp_host.sv: behavioural host that drives select, serial clock, data and pause pins.
// assumes: mode 0 framing; the device samples these pins with its own faster clock.
`default_nettype none

module sfhp_host (
   output logic      select_n_o,
   output logic      sck_o,
   output logic      si_o,
   output logic      hold_n_o,
   input  wire logic so_i,
   input  wire logic so_oe_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // half serial clock period; raised by the bench to act as a slow host
   realtime half_ns = 62.5;

   initial begin
      select_n_o = 1'b1;
      sck_o      = 1'b0;
      si_o       = 1'b0;
      hold_n_o   = 1'b1;
   end

   // ==========================================================
   // framing
   task automatic sel(input logic v);
      #(half_ns);
      select_n_o = v;
      // a released data line must not keep its last level
      if (v) si_o = ~si_o;
      #(4 * half_ns);
   endtask : sel

   task automatic xbyte(input logic [7:0] tx, input int pz, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         si_o = tx[i];
         #(half_ns);
         sck_o = 1'b1;
         rx[i] = so_i;
         #(half_ns);
         sck_o = 1'b0;
         if (i == pz) pause();
      end
   endtask : xbyte

   // ==========================================================
   // pause handling
   task automatic pause;
      #(half_ns);
      hold_n_o = 1'b0;
      // junk clocks and data the paused device must ignore
      repeat (2) begin
         #(half_ns);
         si_o = ~si_o;
         sck_o = 1'b1;
         #(half_ns);
         sck_o = 1'b0;
      end
      #(half_ns);
      hold_n_o = 1'b1;
      #(half_ns);
   endtask : pause

   task automatic abandon;
      #(half_ns);
      hold_n_o = 1'b0;
      #(2 * half_ns);
      select_n_o = 1'b1;
      si_o = ~si_o;
      #(2 * half_ns);
      hold_n_o = 1'b1;
      #(4 * half_ns);
   endtask : abandon
endmodule : sfhp_host

`default_nettype wire

// *** verification/sfhp_core_properties.sv ***
// sfhp_core_properties.sv: port-level checks of the status and protect block.
// assumes: bound to sfhp_core; one clock domain with synchronous active-high reset.
`default_nettype none
`include "sfhp_regs.svh"

module sfhp_core_properties (
   input wire logic                     clk_i,
   input wire logic                     rst_i,
   input wire logic                     select_n_i,
   input wire logic                     sck_i,
   input wire logic                     hold_n_i,
   input wire logic                     guard_n_i,
   input wire logic                     op_running_i,
   input wire logic                     op_done_i,
   input wire logic                     so_oe_o,
   input wire logic                     paused_o,
   input wire logic                     busy_o,
   input wire logic                     write_enable_latch_o,
   input wire logic [2:0]               protect_level_o,
   input wire logic                     protect_bottom_select_o,
   input wire logic                     protect_lockdown_o,
   input wire logic                     nv_store_o,
   input wire logic                     op_start_o,
   input wire sfhp_pkg::sfhp_kind_t     op_kind_o,
   input wire logic [`SFHP_ADDR_W-1:0]  op_addr_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // is 64K block k inside the area picked by level and bottom select
   function automatic logic prot(input logic [2:0] l, input logic b, input logic [3:0] k);
      logic [4:0] n;
      n = (l == 3'h0) ? 5'h00 : (l > 3'h4) ? 5'h10 : 5'(5'h01 << (l - 3'h1));
      return b ? ({1'b0, k} < n) : ({1'b0, k} >= 5'h10 - n);
   endfunction : prot

   hide_when_paused_a: assert property (paused_o |-> !so_oe_o)
      else $error("output driven while paused");
   busy_mirror_a: assert property (busy_o == op_running_i)
      else $error("busy differs from engine");
   done_clears_latch_a: assert property (op_done_i && op_running_i |=> !write_enable_latch_o)
      else $error("latch kept after completion");
   start_needs_latch_a: assert property (op_start_o |-> write_enable_latch_o)
      else $error("start without latch");
   start_engine_idle_a: assert property (op_start_o |-> !$past(op_running_i))
      else $error("start while engine ran");
   chip_erase_clear_a: assert property (op_start_o && op_kind_o == sfhp_pkg::SFHP_KIND_CHIP
      |-> protect_level_o == 3'h0 && !protect_bottom_select_o)
      else $error("chip erase under protection");
   target_protected_a: assert property (op_start_o && op_kind_o != sfhp_pkg::SFHP_KIND_CHIP
      |-> !prot(protect_level_o, protect_bottom_select_o, op_addr_o[19:16]))
      else $error("start in protected block");
   lock_freezes_a: assert property (!guard_n_i && protect_lockdown_o
      |=> $stable({protect_level_o, protect_bottom_select_o, protect_lockdown_o}))
      else $error("locked bits changed");
   store_on_change_a: assert property ($changed({protect_level_o, protect_bottom_select_o,
      protect_lockdown_o}) && !$past(rst_i, 2) |-> nv_store_o)
      else $error("bits changed without store");
   pause_enter_a: assert property ($fell(hold_n_i) && !sck_i && !select_n_i |-> ##6 paused_o)
      else $error("pause not entered");
   abandon_pause_a: assert property ($rose(select_n_i) |-> ##6 !paused_o)
      else $error("pause kept after deselect");
   pause_exit_a: assert property (hold_n_i [*6] |-> !paused_o)
      else $error("pause kept with pin high");
endmodule : sfhp_core_properties

bind sfhp_core sfhp_core_properties u_props (.clk_i, .rst_i, .select_n_i, .sck_i, .hold_n_i,
   .guard_n_i, .op_running_i, .op_done_i, .so_oe_o, .paused_o, .busy_o, .write_enable_latch_o,
   .protect_level_o, .protect_bottom_select_o, .protect_lockdown_o, .nv_store_o, .op_start_o,
   .op_kind_o, .op_addr_o);

`default_nettype wire

// *** verification/sfhp_core_tb.sv ***
// sfhp_core_tb.sv: self-checking bench for the status and protect block.
// assumes: sfhp_host drives the serial pins; the checker is bound to the design.
`default_nettype none

module sfhp_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic             clk_i = 1'b0, rst_i = 1'b1, guard_n_i = 1'b1;
   logic             op_running_i = 1'b0, op_done_i = 1'b0;
   logic [5:0]       nv_restore_i = 6'h00;
   wire logic        select_n, sck, si, hold_n, so, so_oe, paused, busy;
   wire logic        write_enable_latch, bottom, lock, nv_store, op_start;
   wire logic [2:0]  level;
   wire logic [1:0]  op_kind;
   wire logic [23:0] op_addr;
   wire logic [5:0]  nv_data;
   logic [4:0]       xn;
   logic [2:0]       e_lvl;
   logic             e_bot, e_lock, e_wel;
   logic [7:0]       d, rx;
   logic [25:0]      xs;
   logic [4:0]       nv_q[$];
   logic [25:0]      st_q[$];
   int               n_mismatch = 0, n_tests = 0;
   logic [7:0]       ops[6] = '{8'h02, 8'h20, 8'hD7, 8'hD8, 8'h60, 8'hC7};
   logic [1:0]       kinds[6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3};

   sfhp_host host (.select_n_o(select_n), .sck_o(sck), .si_o(si), .hold_n_o(hold_n),
      .so_i(so), .so_oe_i(so_oe));
   sfhp_core uut (.clk_i(clk_i), .rst_i(rst_i), .clk_en_i(1'b1), .select_n_i(select_n),
      .sck_i(sck), .si_i(si), .hold_n_i(hold_n), .guard_n_i(guard_n_i),
      .nv_restore_i(nv_restore_i), .op_running_i(op_running_i), .op_done_i(op_done_i),
      .so_o(so), .so_oe_o(so_oe), .paused_o(paused), .busy_o(busy),
      .write_enable_latch_o(write_enable_latch), .protect_level_o(level), .protect_bottom_select_o(bottom),
      .protect_lockdown_o(lock), .nv_store_o(nv_store), .nv_store_data_o(nv_data),
      .op_start_o(op_start), .op_kind_o(op_kind), .op_addr_o(op_addr));

   initial begin
      forever #4 clk_i = ~clk_i;
   end

   // ==========================================================
   // checking and verdict
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict

   // refused commands must leave no event, so an empty queue is itself a mismatch
   always @(posedge clk_i) begin
      if (!rst_i && nv_store) begin
         if (nv_q.size() == 0) check("extra store", 32'h1, 32'h0);
         else begin
            xn = nv_q.pop_front();
            check("store", 32'({lock, bottom, level}), 32'(xn));
            check("store data", 32'(nv_data), 32'({xn[4], 1'b0, xn[3:0]}));
         end
      end
      if (!rst_i && op_start) begin
         if (st_q.size() == 0) check("extra start", 32'h1, 32'h0);
         else begin
            xs = st_q.pop_front();
            check("start", 32'({op_kind, (xs[25:24] == 2'h3) ? 24'h0 : op_addr}), 32'(xs));
         end
      end
   end

   // ==========================================================
   // serial commands
   task automatic settle;
      repeat (12) @(negedge clk_i);
   endtask : settle

   task automatic frame(input logic [39:0] b, input int n, input int pz, output logic [7:0] r);
      host.sel(1'b0);
      for (int k = 0; k < n; k++) host.xbyte(b[39 - 8 * k -: 8], (k == 1) ? pz : -1, r);
      host.sel(1'b1);
   endtask : frame

   task automatic write_enable_cmd;
      logic [7:0] r;
      frame({8'h06, 32'h0}, 1, -1, r);
      e_wel = 1'b1;
   endtask : write_enable_cmd

   task automatic rdsr(input int pz);
      logic [7:0] r;
      frame({8'h05, 32'h0}, 2, pz, r);
      check("status", 32'(r), 32'({e_lock, 1'b0, e_bot, e_lvl, e_wel, op_running_i}));
   endtask : rdsr

   task automatic status_write_cmd(input logic [7:0] v, input int pz);
      logic [7:0] r;
      write_enable_cmd();
      // noted before the frame: the store pulse comes before the frame task returns
      if (guard_n_i || !e_lock) begin
         {e_lock, e_bot, e_lvl} = {v[7], v[5], v[4:2]};
         nv_q.push_back({v[7], v[5], v[4:2]});
         e_wel = 1'b0;
      end
      frame({8'h01, v, 24'h0}, 2, pz, r);
      settle();
   endtask : status_write_cmd

   task automatic arr(input logic [7:0] op, input logic [23:0] a, input logic [1:0] kind,
                      input logic ok);
      logic [7:0] r;
      write_enable_cmd();
      if (ok) st_q.push_back({kind, (kind == 2'h3) ? 24'h0 : a});
      frame({op, a, 8'h5A}, (kind == 2'h3) ? 1 : (op == 8'h02) ? 5 : 4, -1, r);
      settle();
      if (ok) begin
         @(negedge clk_i) op_running_i = 1'b1;
         rdsr(-1);
         frame({8'h20, 24'h0F0000, 8'h00}, 4, -1, r);
         @(negedge clk_i) op_done_i = 1'b1;
         @(negedge clk_i) op_done_i = 1'b0;
         op_running_i = 1'b0;
         e_wel = 1'b0;
         settle();
         check("latch", 32'(write_enable_latch), 32'h0);
      end
   endtask : arr

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'hA8C0B502));
      d = 8'($urandom());
      // reserved restore slot fed the opposite of lockdown so a wrong packing shows
      nv_restore_i = {d[5], ~d[5], d[3:0]};
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (3) @(negedge clk_i);
      {e_lock, e_bot, e_lvl, e_wel} = {nv_restore_i[5], nv_restore_i[3:0], 1'b0};
      check("restore", 32'({lock, bottom, level}), 32'({e_lock, e_bot, e_lvl}));
      check("idle", 32'({write_enable_latch, busy, paused}), 32'h0);
      rdsr(-1);
      d = 8'($urandom()) | 8'h40;
      status_write_cmd(d, -1);
      rdsr(-1);
      status_write_cmd(8'h00, -1);
      @(negedge clk_i) guard_n_i = 1'b0;
      status_write_cmd(8'h9C, 3);
      host.half_ns = 200.0;
      status_write_cmd(8'h00, -1);
      host.half_ns = 62.5;
      rdsr(5);
      @(negedge clk_i) guard_n_i = 1'b1;
      status_write_cmd(8'h24, -1);
      rdsr(-1);
      frame({8'h20, 24'h050000, 8'h00}, 4, -1, rx);
      arr(8'h20, 24'h00F000, 2'h1, 1'b0);
      arr(8'hD8, 24'h0F1234, 2'h2, 1'b1);
      arr(8'h60, 24'h0, 2'h3, 1'b0);
      write_enable_cmd();
      host.sel(1'b0);
      host.xbyte(8'h01, -1, rx);
      host.abandon();
      settle();
      check("abandon", 32'(paused), 32'h0);
      status_write_cmd(8'h00, -1);
      for (int i = 0; i < 6; i++) arr(ops[i], {4'h0, 20'($urandom())}, kinds[i], 1'b1);
      write_enable_cmd();
      frame({8'h04, 32'h0}, 1, -1, rx);
      e_wel = 1'b0;
      settle();
      rdsr(-1);
      check("pending", 32'(nv_q.size() + st_q.size()), 32'h0);
      print_verdict();
   end

   initial begin
      #700000;
      n_mismatch++;
      print_verdict();
   end
endmodule : sfhp_core_tb

`default_nettype wire
